// [design/bfs_supervisor.sv]
// bfs_supervisor: breaker failure supervision with backup trip and latched lock
// assumes pins asynchronous to core_clk, a one-cycle register port on core_clk
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module bfs_supervisor #(
  parameter int unsigned TICK_CYC = bfs_pkg::TICK_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic trip_ext,
  input wire logic trip_cur,
  input wire logic trip_oth,
  input wire logic [2:0] extra_trig,
  input wire logic cur_above,
  input wire logic pos_open,
  input wire logic ack_btn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic fail_trip,
  output logic lock,
  output logic irq
);
  localparam int NS = 9;
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

  typedef struct packed {
    bfs_pkg::bfs_state_e st;
    logic [15:0] pre_cnt;
    logic [15:0] ms_cnt;
    logic trip;
    logic lock;
    logic [1:0] meth;
    logic [1:0] trig_mode;
    logic [2:0] xen;
    logic [15:0] sup_time;
    logic [3:0] istat;
    logic [3:0] imask;
    logic irq;
    logic ack_d;
    logic [31:0] rdata;
  } bfs_core_s;

  bfs_core_s q;
  bfs_core_s nxt;

  logic [NS-1:0] pins_s;
  logic t_ext;
  logic t_cur;
  logic t_oth;
  logic [2:0] x_trig;
  logic cur_hi;
  logic pos_op;
  logic ack_s;
  logic sel_trig;
  logic trig;
  logic opened;
  logic fail_cond;
  logic tick;
  logic expired;
  logic ack_p;
  logic istat_clr;
  logic [3:0] ev;

  // every pin passes the two-flop synchroniser before use
  bfs_sync_if #(.W(NS)) sif ();
  assign sif.raw = {ack_btn, pos_open, cur_above, extra_trig, trip_oth, trip_cur, trip_ext};

  bfs_sync #(.W(NS)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .sif(sif)
  );

  assign pins_s = sif.synced;
  assign t_ext = pins_s[0];
  assign t_cur = pins_s[1];
  assign t_oth = pins_s[2];
  assign x_trig = pins_s[5:3];
  assign cur_hi = pins_s[6];
  assign pos_op = pins_s[7];
  assign ack_s = pins_s[8];

  // breaker-assigned trips chosen by trigger mode
  always_comb begin
    unique case (q.trig_mode)
      bfs_pkg::TRIG_ALL: sel_trig = t_ext | t_cur | t_oth;
      bfs_pkg::TRIG_EXT: sel_trig = t_ext;
      bfs_pkg::TRIG_CUR: sel_trig = t_cur;
      bfs_pkg::TRIG_NONE: sel_trig = 1'b0;
    endcase
  end

  // extra inputs act regardless of breaker assignment
  assign trig = sel_trig | (|(x_trig & q.xen));

  // opening criterion and failure condition per method
  always_comb begin
    case (q.meth)
      bfs_pkg::METH_CUR: begin
        opened = ~cur_hi;
        fail_cond = cur_hi;
      end
      bfs_pkg::METH_POS: begin
        opened = pos_op;
        fail_cond = ~pos_op;
      end
      // illegal code 3 falls back to the strictest check
      default: begin
        opened = ~cur_hi & pos_op;
        fail_cond = cur_hi & ~pos_op;
      end
    endcase
  end

  // millisecond prescaler runs only while supervising
  assign tick = (q.st == bfs_pkg::ST_RUNNING) && (q.pre_cnt == TICK_LAST);
  assign expired = tick && (q.ms_cnt <= 16'h0001);

  // operator acknowledge: button rising edge or register write
  assign ack_p = (ack_s & ~q.ack_d) |
                 (reg_we && reg_addr == bfs_pkg::ACK_OFS && reg_wdata[bfs_pkg::ACK_BIT]);
  assign istat_clr = reg_re && reg_addr == bfs_pkg::ISTAT_OFS;

  // next-state logic for the whole block
  always_comb begin
    nxt = q;
    nxt.rdata = 32'h0000_0000;
    nxt.ack_d = ack_s;
    ev = 4'h0;
    // supervision sequence
    unique case (q.st)
      bfs_pkg::ST_STANDBY: begin
        if (trig) begin
          nxt.st = bfs_pkg::ST_RUNNING;
          nxt.pre_cnt = 16'h0000;
          nxt.ms_cnt = q.sup_time;
          ev[bfs_pkg::IRQ_START] = 1'b1;
        end
      end
      bfs_pkg::ST_RUNNING: begin
        nxt.pre_cnt = tick ? 16'h0000 : q.pre_cnt + 16'h0001;
        if (tick) begin
          nxt.ms_cnt = q.ms_cnt - 16'h0001;
        end
        if (opened) begin
          // trigger level decides, not its history
          if (trig) begin
            nxt.st = bfs_pkg::ST_REJECTED;
            ev[bfs_pkg::IRQ_REJ] = 1'b1;
          end else begin
            nxt.st = bfs_pkg::ST_STANDBY;
          end
        end else if (expired) begin
          if (fail_cond) begin
            nxt.st = bfs_pkg::ST_TRIPPED;
            nxt.trip = 1'b1;
            nxt.lock = 1'b1;
            ev[bfs_pkg::IRQ_TRIP] = 1'b1;
          end else if (trig) begin
            nxt.st = bfs_pkg::ST_REJECTED;
            ev[bfs_pkg::IRQ_REJ] = 1'b1;
          end else begin
            nxt.st = bfs_pkg::ST_STANDBY;
          end
        end
        // otherwise keep timing even with trigger gone
      end
      bfs_pkg::ST_TRIPPED: begin
        // backup trip held until all triggers drop
        if (!trig) begin
          nxt.st = bfs_pkg::ST_STANDBY;
          nxt.trip = 1'b0;
        end
      end
      bfs_pkg::ST_REJECTED: begin
        if (!trig) begin
          nxt.st = bfs_pkg::ST_STANDBY;
        end
      end
    endcase
    // lock clears only by acknowledge; a new trip wins
    if (ack_p && q.lock && !ev[bfs_pkg::IRQ_TRIP]) begin
      nxt.lock = 1'b0;
      ev[bfs_pkg::IRQ_ACK] = 1'b1;
    end
    if (ev[bfs_pkg::IRQ_TRIP]) begin
      nxt.lock = 1'b1;
    end
    // register writes
    if (reg_we) begin
      unique case (reg_addr)
        bfs_pkg::CTRL_OFS: begin
          nxt.meth = reg_wdata[bfs_pkg::CTRL_METH_LSB +: 2];
          nxt.trig_mode = reg_wdata[bfs_pkg::CTRL_TRIG_LSB +: 2];
          nxt.xen = reg_wdata[bfs_pkg::CTRL_XEN_LSB +: 3];
        end
        bfs_pkg::TIME_OFS: nxt.sup_time = reg_wdata[15:0];
        bfs_pkg::IMASK_OFS: nxt.imask = reg_wdata[3:0];
        default: ;
      endcase
    end
    // register reads, data stand one cycle later
    if (reg_re) begin
      unique case (reg_addr)
        bfs_pkg::CTRL_OFS: begin
          nxt.rdata[bfs_pkg::CTRL_METH_LSB +: 2] = q.meth;
          nxt.rdata[bfs_pkg::CTRL_TRIG_LSB +: 2] = q.trig_mode;
          nxt.rdata[bfs_pkg::CTRL_XEN_LSB +: 3] = q.xen;
        end
        bfs_pkg::TIME_OFS: nxt.rdata[15:0] = q.sup_time;
        bfs_pkg::STAT_OFS: begin
          nxt.rdata[bfs_pkg::STAT_ST_LSB +: 2] = q.st;
          nxt.rdata[bfs_pkg::STAT_TRIP] = q.trip;
          nxt.rdata[bfs_pkg::STAT_LOCK] = q.lock;
          nxt.rdata[bfs_pkg::STAT_TRIG] = trig;
          nxt.rdata[bfs_pkg::STAT_CUR] = cur_hi;
          nxt.rdata[bfs_pkg::STAT_POS] = pos_op;
        end
        bfs_pkg::ISTAT_OFS: nxt.rdata[3:0] = q.istat;
        bfs_pkg::IMASK_OFS: nxt.rdata[3:0] = q.imask;
        default: ;
      endcase
    end
    // sticky events: a new event beats the read clear
    nxt.istat = (istat_clr ? 4'h0 : q.istat) | ev;
    nxt.irq = |(nxt.istat & nxt.imask);
  end

  // single state register; reset loads constants only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q.st <= bfs_pkg::ST_STANDBY;
      q.pre_cnt <= 16'h0000;
      q.ms_cnt <= 16'h0000;
      q.trip <= 1'b0;
      q.lock <= 1'b0;
      q.meth <= bfs_pkg::METH_RST;
      q.trig_mode <= bfs_pkg::TRIG_RST;
      q.xen <= bfs_pkg::XEN_RST;
      q.sup_time <= bfs_pkg::TIME_RST;
      q.istat <= 4'h0;
      q.imask <= bfs_pkg::IMASK_RST;
      q.irq <= 1'b0;
      q.ack_d <= 1'b0;
      q.rdata <= 32'h0000_0000;
    end else begin
      q <= nxt;
    end
  end

  assign reg_rdata = q.rdata;
  assign fail_trip = q.trip;
  assign lock = q.lock;
  assign irq = q.irq;

  // checks on the supervision behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_fail_expiry;
    q.st == bfs_pkg::ST_RUNNING && !opened && expired && fail_cond;
  endsequence

  sequence s_open_with_trig;
    q.st == bfs_pkg::ST_RUNNING && opened && trig;
  endsequence

  property p_trip_on_expiry;
    s_fail_expiry |=> fail_trip && lock ##1 (fail_trip || !trig);
  endproperty
  a_trip_on_expiry: assert property (p_trip_on_expiry)
    else $error("trip not raised at expiry");

  property p_cur_fail;
    q.st == bfs_pkg::ST_RUNNING && q.meth == bfs_pkg::METH_CUR && expired && cur_hi
      |=> fail_trip;
  endproperty
  a_cur_fail: assert property (p_cur_fail)
    else $error("current mode missed failure");

  property p_pos_fail;
    q.st == bfs_pkg::ST_RUNNING && q.meth == bfs_pkg::METH_POS && expired && !pos_op
      |=> fail_trip;
  endproperty
  a_pos_fail: assert property (p_pos_fail)
    else $error("position mode missed failure");

  property p_comb_no_fail;
    q.st == bfs_pkg::ST_RUNNING && q.meth == bfs_pkg::METH_COMB && expired
      && !(cur_hi && !pos_op) |=> !fail_trip;
  endproperty
  a_comb_no_fail: assert property (p_comb_no_fail)
    else $error("combined mode tripped wrongly");

  property p_keep_running;
    q.st == bfs_pkg::ST_RUNNING && !trig && !opened && !expired
      |=> q.st == bfs_pkg::ST_RUNNING;
  endproperty
  a_keep_running: assert property (p_keep_running)
    else $error("timer stopped on trigger drop");

  property p_stop_on_open;
    q.st == bfs_pkg::ST_RUNNING && opened |=> !fail_trip ##1 !$rose(fail_trip);
  endproperty
  a_stop_on_open: assert property (p_stop_on_open)
    else $error("trip after opening detected");

  property p_reject;
    s_open_with_trig |=> q.st == bfs_pkg::ST_REJECTED;
  endproperty
  a_reject: assert property (p_reject)
    else $error("no rejected state on opening");

  property p_reject_exit;
    q.st == bfs_pkg::ST_REJECTED && !trig |=> q.st == bfs_pkg::ST_STANDBY;
  endproperty
  a_reject_exit: assert property (p_reject_exit)
    else $error("rejected state not left");

  property p_lock_with_trip;
    $rose(fail_trip) |-> $rose(lock) || $past(lock);
  endproperty
  a_lock_with_trip: assert property (p_lock_with_trip)
    else $error("lock not raised with trip");

  property p_lock_hold;
    lock && !ack_p |=> lock;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("lock dropped without acknowledge");

  property p_lock_ack;
    lock && ack_p && !ev[bfs_pkg::IRQ_TRIP] |=> !lock;
  endproperty
  a_lock_ack: assert property (p_lock_ack)
    else $error("lock not cleared by acknowledge");

  property p_start;
    q.st == bfs_pkg::ST_STANDBY && trig |=> q.st == bfs_pkg::ST_RUNNING;
  endproperty
  a_start: assert property (p_start)
    else $error("trigger did not start supervision");

  property p_reset;
    @(posedge core_clk) disable iff (1'b0)
      rst |=> q.st == bfs_pkg::ST_STANDBY && !fail_trip && !lock;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not clear outputs");
endmodule : bfs_supervisor

// [design/bfs_pkg.sv]
// bfs_pkg: constants, register map and state types of the breaker failure supervisor
// assumes one 50 MHz core clock and a synchronous active-high reset
// Contract
// - method: current, position or both combined
// - current mode: fail if current stays high
// - position mode: fail if not shown open
// - combined: fail only if both criteria fail
// - timer keeps running after trigger drops
// - expiry without stop asserts backup trip; combined mode with one criterion failing enters rejected or standby
// - opening per method stops the timer
// - opening with trigger active enters rejected
// - rejected returns to standby when triggers drop
// - locking output rises with the trip
// - locking stays until operator acknowledge
// - three extra trigger inputs may start supervision
// - trigger mode picks breaker trips used
package bfs_pkg;
  // timing: the supervision time is counted in 1 ms ticks
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_MHZ * TICK_US;
  localparam int ADDR_W = 8;
  localparam int TIME_W = 16;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TIME_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] ISTAT_OFS = 8'h0c;
  localparam logic [7:0] IMASK_OFS = 8'h10;
  localparam logic [7:0] ACK_OFS = 8'h14;
  // control fields
  localparam int CTRL_METH_LSB = 0;
  localparam int CTRL_TRIG_LSB = 2;
  localparam int CTRL_XEN_LSB = 4;
  localparam int ACK_BIT = 0;
  // status fields
  localparam int STAT_ST_LSB = 0;
  localparam int STAT_TRIP = 2;
  localparam int STAT_LOCK = 3;
  localparam int STAT_TRIG = 4;
  localparam int STAT_CUR = 5;
  localparam int STAT_POS = 6;
  // interrupt event bits
  localparam int IRQ_START = 0;
  localparam int IRQ_TRIP = 1;
  localparam int IRQ_REJ = 2;
  localparam int IRQ_ACK = 3;
  // reset values
  localparam logic [1:0] METH_RST = 2'h0;
  localparam logic [1:0] TRIG_RST = 2'h0;
  localparam logic [2:0] XEN_RST = 3'h7;
  localparam logic [15:0] TIME_RST = 16'h0064;
  localparam logic [3:0] IMASK_RST = 4'h0;
  // detection methods; code 3 is illegal and acts as combined
  localparam logic [1:0] METH_CUR = 2'h0;
  localparam logic [1:0] METH_POS = 2'h1;
  localparam logic [1:0] METH_COMB = 2'h2;
  // trigger modes
  localparam logic [1:0] TRIG_ALL = 2'h0;
  localparam logic [1:0] TRIG_EXT = 2'h1;
  localparam logic [1:0] TRIG_CUR = 2'h2;
  localparam logic [1:0] TRIG_NONE = 2'h3;
  typedef enum logic [1:0] {
    ST_STANDBY = 2'h0,
    ST_RUNNING = 2'h1,
    ST_TRIPPED = 2'h3,
    ST_REJECTED = 2'h2
  } bfs_state_e;
endpackage : bfs_pkg

// [design/bfs_sync_if.sv]
// bfs_sync_if: raw pin levels in, synchronised levels out
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface bfs_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport user (output raw, input synced);
  modport sync_mp (input raw, output synced);
endinterface : bfs_sync_if

// [design/bfs_sync.sv]
// bfs_sync: two-flop synchroniser for a group of pin levels
// assumes raw inputs are asynchronous to core_clk
`timescale 1ns/1ps
module bfs_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  bfs_sync_if.sync_mp sif
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bfs_sync_s;

  bfs_sync_s q;
  bfs_sync_s nxt;

  // first stage feeds only the second stage
  always_comb begin
    nxt.s1 = sif.raw;
    nxt.s2 = q.s1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= nxt;
    end
  end

  assign sif.synced = q.s2;
endmodule : bfs_sync

// [verification/bfs_breaker_model.sv]
// bfs_breaker_model: monitored breaker as seen by the supervisor (current, position)
// assumes trip commands from the bench; opening delay given in core_clk cycles
`timescale 1ns/1ps
module bfs_breaker_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic trip_cmd,
  input wire logic reclose,
  input wire logic [7:0] open_cyc,
  input wire logic cur_stuck,
  input wire logic pos_stuck,
  output logic cur_above,
  output logic pos_open
);
  int cnt;
  logic open_ff;

  // contacts part a set time after the trip coil is energised
  always @(posedge core_clk) begin
    if (rst || reclose) begin
      cnt <= 0;
      open_ff <= 1'b0;
    end else if (!open_ff && (trip_cmd || cnt != 0)) begin
      cnt <= cnt + 1;
      open_ff <= (cnt == int'(open_cyc));
    end
  end

  // a welded pole or a faulty indicator hides the opening
  assign cur_above = !open_ff || cur_stuck;
  assign pos_open = open_ff && !pos_stuck;
endmodule : bfs_breaker_model

// [verification/testbench.sv]
// testbench: self-checking run of the breaker failure supervisor
// assumes the breaker model beside it and a 10-cycle tick to keep runs short
`timescale 1ns/1ps
module testbench;
  localparam int TICK = 10;
  localparam int T = 4 * TICK;
  logic core_clk, rst, reclose, cur_stuck, pos_stuck, ack_btn, reg_we, reg_re;
  logic fail_trip, lock, irq, cur_above, pos_open, cs_v, ps_v, exp_t, e;
  logic [5:0] src;
  logic [7:0] reg_addr, open_cyc;
  logic [31:0] reg_wdata, reg_rdata, cv;
  int n_fail = 0;
  int check_count = 0;
  int n, m, k, tm, s;

  // 50 MHz core clock
  always #10 core_clk = ~core_clk;

  bfs_supervisor #(.TICK_CYC(TICK)) bfs_supervisor_i (
    .core_clk(core_clk), .rst(rst), .trip_ext(src[0]), .trip_cur(src[1]),
    .trip_oth(src[2]), .extra_trig(src[5:3]), .cur_above(cur_above),
    .pos_open(pos_open), .ack_btn(ack_btn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .fail_trip(fail_trip), .lock(lock), .irq(irq));

  bfs_breaker_model bfs_breaker_model_i (
    .core_clk(core_clk), .rst(rst), .trip_cmd(|src), .reclose(reclose),
    .open_cyc(open_cyc), .cur_stuck(cur_stuck), .pos_stuck(pos_stuck),
    .cur_above(cur_above), .pos_open(pos_open));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so look mid-cycle
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge core_clk);
    reg_re <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, exp);
  endtask : rc

  task automatic trg(input logic [5:0] v);
    @(posedge core_clk);
    src <= v;
  endtask : trg

  task automatic cyc(input int c);
    repeat (c) @(negedge core_clk);
  endtask : cyc

  task automatic brk(input logic c, input logic p);
    @(posedge core_clk);
    cur_stuck <= c;
    pos_stuck <= p;
    reclose <= 1'b1;
    @(posedge core_clk);
    reclose <= 1'b0;
  endtask : brk

  function automatic logic [31:0] stv(input logic [1:0] st, input logic tr,
                                      input logic lk, input logic tg);
    stv = {25'h0, !ps_v, cs_v, tg, lk, tr, st};
  endfunction : stv

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    end_sim();
  end

  // main sequence
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    src = 6'h00;
    reclose = 1'b0;
    cur_stuck = 1'b0;
    pos_stuck = 1'b0;
    ack_btn = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    open_cyc = 8'h0a;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    cyc(1);
    chk({fail_trip, lock, irq}, 32'h0);
    rc(bfs_pkg::CTRL_OFS, 32'h70);
    rc(bfs_pkg::TIME_OFS, 32'h64);
    rc(bfs_pkg::IMASK_OFS, 32'h0);
    rc(8'h1c, 32'h0);
    // 40 cycles comfortably exceed the 10-cycle opening plus pin sync
    wr(bfs_pkg::TIME_OFS, 32'h4);
    wr(bfs_pkg::IMASK_OFS, 32'h2);
    // every method against every combination of stuck criteria; code 3 must act as combined
    for (m = 0; m < 4; m++) begin
      for (k = 0; k < 4; k++) begin
        cs_v = k[1];
        ps_v = k[0];
        exp_t = (m == 0) ? cs_v : (m == 1) ? ps_v : (cs_v && ps_v);
        wr(bfs_pkg::CTRL_OFS, 32'h70 | m);
        brk(cs_v, ps_v);
        trg(6'h01);
        n = 0;
        while (fail_trip !== 1'b1 && n < 60) begin
          @(negedge core_clk);
          n++;
        end
        chk(fail_trip, exp_t);
        if (exp_t) begin
          chk(n >= T && n <= T + 10, 1'b1);
          chk(lock, 1'b1);
          rc(bfs_pkg::STAT_OFS, stv(bfs_pkg::ST_TRIPPED, 1'b1, 1'b1, 1'b1));
          chk(irq, 1'b1);
          rc(bfs_pkg::ISTAT_OFS, 32'h3);
        end else begin
          rc(bfs_pkg::STAT_OFS, stv(bfs_pkg::ST_REJECTED, 1'b0, 1'b0, 1'b1));
          chk(irq, 1'b0);
          rc(bfs_pkg::ISTAT_OFS, 32'h5);
        end
        trg(6'h00);
        cyc(4);
        chk({fail_trip, irq}, 32'h0);
        rc(bfs_pkg::STAT_OFS, stv(bfs_pkg::ST_STANDBY, 1'b0, exp_t, 1'b0));
        if (exp_t) begin
          if (m[0]) begin
            wr(bfs_pkg::ACK_OFS, 32'h1);
          end else begin
            @(posedge core_clk);
            ack_btn <= 1'b1;
            @(posedge core_clk);
            ack_btn <= 1'b0;
          end
          cyc(5);
          chk(lock, 1'b0);
          rc(bfs_pkg::ISTAT_OFS, 32'h8);
        end
      end
    end
    // slow breaker, trigger released early: the timer still runs out
    cs_v = 1'b0;
    ps_v = 1'b0;
    wr(bfs_pkg::CTRL_OFS, 32'h70);
    open_cyc <= 8'h50;
    brk(1'b0, 1'b0);
    trg(6'h01);
    cyc(3);
    trg(6'h00);
    n = 3;
    while (lock !== 1'b1 && n < 80) begin
      @(negedge core_clk);
      n++;
    end
    chk(n >= T && n <= T + 10, 1'b1);
    cyc(100);
    chk(lock, 1'b1);
    wr(bfs_pkg::ACK_OFS, 32'h1);
    cyc(2);
    chk(lock, 1'b0);
    rc(bfs_pkg::ISTAT_OFS, 32'hb);
    open_cyc <= 8'h0a;
    // trigger modes and extra inputs; mode 4 here is none with extras disabled
    for (tm = 0; tm < 5; tm++) begin
      for (s = 0; s < 6; s++) begin
        cv = (tm == 4) ? 32'h0c : (32'h70 | (tm << 2));
        if (s == 0) e = (tm == bfs_pkg::TRIG_ALL || tm == bfs_pkg::TRIG_EXT);
        else if (s == 1) e = (tm == bfs_pkg::TRIG_ALL || tm == bfs_pkg::TRIG_CUR);
        else if (s == 2) e = (tm == bfs_pkg::TRIG_ALL);
        else e = (tm < 4);
        wr(bfs_pkg::CTRL_OFS, cv);
        brk(1'b0, 1'b0);
        trg(6'h01 << s);
        cyc(3);
        trg(6'h00);
        cyc(20);
        rc(bfs_pkg::ISTAT_OFS, {31'h0, e});
      end
    end
    end_sim();
  end
endmodule : testbench
